// [uart_pkg.sv]
// How it works
// R1: Software sets ninth transmit bit before low byte.
// R2: Transmit empty flag high exactly while buffer empty.
// R3: Data write loads buffer, clears empty flag.
// R4: Empty request stays while enabled and empty.
// R5: Complete flag sets when frame done, buffer empty.
// R6: Complete flag cleared by service or one-write.
// R7: Complete request raised once flag set, enabled.
// R8: Parity bit sent after data, before stop.
// R9: Transmitter disable waits until shifter, buffer empty.
// R10: Receiver enable takes over receive pin.
// R11: Synchronous mode clocks receiver from external clock.
// R12: Shift bits until first stop; ignore second.
// R13: First stop moves frame into receive buffer.
// R14: Unused upper data bits read as zero.
// R15: Software reads ninth bit, status before data.
// R16: Ninth bit, error flags travel per entry.
// R17: Receive flag high while buffer holds data.
// R18: Receiver disable flushes buffer, clears flag.
// R19: Receive request stays while flag set, enabled.
// R20: Software writes zero at empty flag position.
// R21: Buffer moves to shifter when idle or done.
// R22: Low start, LSB first, parity, high stops.
// R23: Two entry buffer; overrun on full, waiting, start.
// R24: Ninth transmit bit captured with low byte.
package uart_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_DATA = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_CONTROL = 5'h08;
	localparam logic [4:0] OFS_FORMAT = 5'h0c;
	localparam logic [4:0] OFS_BAUD = 5'h10;
	// Status bits
	localparam int ST_RXC = 0;
	localparam int ST_TXC = 1;
	localparam int ST_TX_BUF_EMPTY_FLAG = 2;
	localparam int ST_FE = 3;
	localparam int ST_DOR = 4;
	localparam int ST_PE = 5;
	// Control bits
	localparam int CT_RX_ENABLE = 0;
	localparam int CT_TX_ENABLE = 1;
	localparam int CT_RX_COMPLETE_IRQ_ENABLE = 2;
	localparam int CT_TX_COMPLETE_IRQ_ENABLE = 3;
	localparam int CT_TX_EMPTY_IRQ_ENABLE = 4;
	localparam int CT_TXB9 = 5;
	localparam int CT_RXB9 = 6;
	localparam int CT_SYNC = 7;
	// Format fields
	localparam int FM_SIZE_LSB = 0;
	localparam int FM_PAR_ODD = 3;
	localparam int FM_PAR_EN = 4;
	localparam int FM_STOP2 = 5;
	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [5:0] FMT_RESET = 6'h03;
	localparam int BAUD_W = 16;
	localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0000;
	localparam logic [2:0] CHAR9_CODE = 3'h7;
	localparam logic [3:0] CHAR9_BITS = 4'h9;
	localparam logic [3:0] BASE_BITS = 4'h5;
	localparam logic [8:0] FULL_MASK = 9'h1ff;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [1:0] RXBUF_DEPTH = 2'h2;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ninth;
		logic [7:0] data;
		logic fe;
		logic overrun_flag;
		logic pe;
	} rx_entry_t;
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01,
		TX_START = 6'h02,
		TX_DATA = 6'h04,
		TX_PAR = 6'h08,
		TX_STOP1 = 6'h10,
		TX_STOP2 = 6'h20
	} tx_state_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} rx_state_t;
endpackage : uart_pkg

// [tick_div.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Oversample tick divider: one pulse every div_i+1 cycles
// ----------------------------------------------------------------
module tick_div import uart_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [BAUD_W-1:0] div_i,
	output logic tick_o
);
	logic [BAUD_W-1:0] cnt_q;

	// Compare with >= so a smaller divisor written mid-count takes effect at once
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else if (cnt_q >= div_i) begin
			cnt_q <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule : tick_div

// [uart_core.sv]
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
module uart_core import uart_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic rxd_i,
	input wire logic xck_i,
	input wire logic tx_complete_irq_ack_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rxd_owned_o,
	output logic tx_empty_irq_o,
	output logic tx_complete_irq_o,
	output logic rx_complete_irq_o
);
	// ----------------------------------------------------------------
	// Avalon slave: one wait state per access
	// ----------------------------------------------------------------
	logic ack_q, req, wr_acc, rd_acc;
	logic wsel_data, wsel_status, pop;
	logic [31:0] rdata_q;
	logic [7:0] ctrl_q, st_rd, ctrl_rd;
	logic [5:0] fmt_q;
	logic [BAUD_W-1:0] baud_q;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_q;
	assign wr_acc = avs_write_i & ack_q;
	assign rd_acc = avs_read_i & ack_q;
	assign wsel_data = wr_acc & (avs_address_i == OFS_DATA) & avs_byteenable_i[0];
	assign wsel_status = wr_acc & (avs_address_i == OFS_STATUS) & avs_byteenable_i[0];
	assign avs_readdata_o = rdata_q;

	// Ack toggles so back-to-back requests still get one wait state each
	always_ff @(posedge clk_i) begin
		if (!nrst_i) ack_q <= 1'b0;
		else ack_q <= req & ~ack_q;
	end

	// Configuration writes, byte lane 0 except the high baud byte
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl_q <= CTRL_RESET;
			fmt_q <= FMT_RESET;
			baud_q <= BAUD_RESET;
		end else if (wr_acc) begin
			if (avs_address_i == OFS_CONTROL && avs_byteenable_i[0]) ctrl_q <= avs_writedata_i[7:0];
			if (avs_address_i == OFS_FORMAT && avs_byteenable_i[0]) fmt_q <= avs_writedata_i[5:0];
			if (avs_address_i == OFS_BAUD) begin
				if (avs_byteenable_i[0]) baud_q[7:0] <= avs_writedata_i[7:0];
				if (avs_byteenable_i[1]) baud_q[15:8] <= avs_writedata_i[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and bit timing
	// ----------------------------------------------------------------
	logic rxd_m_q, rxd_s_q, xck_m_q, xck_s_q, xck_d_q;
	logic os_tick, sync_mode, xck_rise, xck_fall;

	// Idle line is high, so the receive chain resets high
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			xck_m_q <= 1'b0;
			xck_s_q <= 1'b0;
			xck_d_q <= 1'b0;
		end else begin
			rxd_m_q <= rxd_i;
			rxd_s_q <= rxd_m_q;
			xck_m_q <= xck_i;
			xck_s_q <= xck_m_q;
			xck_d_q <= xck_s_q;
		end
	end

	assign sync_mode = ctrl_q[CT_SYNC];
	assign xck_rise = xck_s_q & ~xck_d_q;
	assign xck_fall = ~xck_s_q & xck_d_q;

	tick_div u_div (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.div_i(baud_q),
		.tick_o(os_tick)
	);

	// Character length from the size code; reserved codes fall back to 5..7
	logic [3:0] nbits;
	logic [8:0] data_mask;
	logic par_en, par_odd, stop2;
	assign nbits = (fmt_q[FM_SIZE_LSB +: 3] == CHAR9_CODE) ? CHAR9_BITS :
		BASE_BITS + {2'b00, fmt_q[FM_SIZE_LSB +: 2]};
	assign data_mask = FULL_MASK >> (CHAR9_BITS - nbits);
	assign par_en = fmt_q[FM_PAR_EN];
	assign par_odd = fmt_q[FM_PAR_ODD];
	assign stop2 = fmt_q[FM_STOP2];

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	tx_state_t tx_st_q;
	logic [8:0] txbuf_q, tsr_q;
	logic txbuf_full_q, tx_active_q, txd_q, tx_par_q, txc_q;
	logic [3:0] tx_cnt_q, tx_bits_q;
	logic tx_bit_en, last_stop, tx_load, txc_clr;

	// Synchronous mode changes data on the falling external edge
	assign tx_bit_en = sync_mode ? xck_fall : (os_tick & (tx_cnt_q == OS_LAST));
	assign last_stop = tx_bit_en & (((tx_st_q == TX_STOP1) & ~stop2) | (tx_st_q == TX_STOP2));
	assign tx_load = tx_active_q & txbuf_full_q & ((tx_st_q == TX_IDLE) | last_stop); // [R21]

	// Buffer: a new write wins over the transfer in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			txbuf_q <= '0;
			txbuf_full_q <= 1'b0;
		end else if (wsel_data) begin
			txbuf_q <= {ctrl_q[CT_TXB9], avs_writedata_i[7:0]}; // [R24]
			txbuf_full_q <= 1'b1; // [R3]
		end else if (tx_load) begin
			txbuf_full_q <= 1'b0; // [R2]
		end
	end

	// Frame sequencer, LSB first, parity between data and stop
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tx_st_q <= TX_IDLE;
			tsr_q <= '0;
			tx_bits_q <= '0;
			tx_par_q <= 1'b0;
			tx_cnt_q <= '0;
			txd_q <= 1'b1;
		end else if (tx_load) begin
			tsr_q <= txbuf_q & data_mask;
			tx_par_q <= (^(txbuf_q & data_mask)) ^ par_odd; // [R8]
			tx_bits_q <= '0;
			tx_cnt_q <= '0;
			tx_st_q <= TX_START;
			txd_q <= 1'b0; // [R22]
		end else begin
			if (os_tick) tx_cnt_q <= tx_cnt_q + 4'h1;
			if (tx_bit_en) begin
				case (tx_st_q)
					TX_START, TX_DATA: begin
						if (tx_bits_q == nbits) begin
							tx_st_q <= par_en ? TX_PAR : TX_STOP1;
							txd_q <= par_en ? tx_par_q : 1'b1; // [R8] [R22]
						end else begin
							tx_st_q <= TX_DATA;
							txd_q <= tsr_q[0];
							tsr_q <= {1'b0, tsr_q[8:1]};
							tx_bits_q <= tx_bits_q + 4'h1;
						end
					end
					TX_PAR: begin
						tx_st_q <= TX_STOP1;
						txd_q <= 1'b1;
					end
					TX_STOP1: tx_st_q <= stop2 ? TX_STOP2 : TX_IDLE;
					TX_STOP2: tx_st_q <= TX_IDLE;
					default: tx_st_q <= TX_IDLE;
				endcase
			end
		end
	end

	// Disable is deferred until nothing is left to send
	always_ff @(posedge clk_i) begin
		if (!nrst_i) tx_active_q <= 1'b0;
		else if (ctrl_q[CT_TX_ENABLE]) tx_active_q <= 1'b1;
		else if (tx_st_q == TX_IDLE && !txbuf_full_q) tx_active_q <= 1'b0; // [R9]
	end

	// Complete flag: setting beats a clear in the same cycle
	assign txc_clr = tx_complete_irq_ack_i | (wsel_status & avs_writedata_i[ST_TXC]); // [R6]
	always_ff @(posedge clk_i) begin
		if (!nrst_i) txc_q <= 1'b0;
		else if (last_stop && !txbuf_full_q) txc_q <= 1'b1; // [R5]
		else if (txc_clr) txc_q <= 1'b0; // [R6]
	end

	assign txd_o = txd_q;
	assign txd_oe_o = tx_active_q; // [R9]
	assign tx_empty_irq_o = ctrl_q[CT_TX_EMPTY_IRQ_ENABLE] & ~txbuf_full_q; // [R4]
	assign tx_complete_irq_o = ctrl_q[CT_TX_COMPLETE_IRQ_ENABLE] & txc_q; // [R7]

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	rx_state_t rx_st_q;
	rx_entry_t hold_q, head;
	rx_entry_t rxbuf_q [RXBUF_DEPTH];
	logic [8:0] rsr_q, rx_aligned;
	logic [3:0] rx_cnt_q, rx_bits_q;
	logic [1:0] rx_count_q;
	logic rx_en, rx_in, rx_samp, rx_parbit_q, start_seen, frame_done, frame_fe;
	logic hold_v_q, push, rx_full, wr_ptr_q, rd_ptr_q, rx_complete_flag;

	assign rx_en = ctrl_q[CT_RX_ENABLE];
	assign rxd_owned_o = rx_en; // [R10]
	assign rx_in = rx_en ? rxd_s_q : 1'b1; // [R10]
	// External clock rising edge samples in synchronous mode
	assign rx_samp = sync_mode ? xck_rise : (os_tick & (rx_cnt_q == OS_LAST)); // [R11]
	assign start_seen = sync_mode ? (rx_st_q == RX_IDLE) & xck_rise & ~rx_in :
		(rx_st_q == RX_START) & os_tick & (rx_cnt_q == OS_MID) & ~rx_in;
	assign frame_done = (rx_st_q == RX_STOP) & rx_samp; // [R13]
	assign frame_fe = ~rx_in;
	assign rx_aligned = rsr_q >> (CHAR9_BITS - nbits); // [R14]

	// Start is checked at mid bit; later samples fall at each bit centre
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !rx_en) begin
			rx_st_q <= RX_IDLE; // [R18]
			rsr_q <= '0;
			rx_bits_q <= '0;
			rx_cnt_q <= '0;
			rx_parbit_q <= 1'b0;
		end else begin
			if (os_tick) rx_cnt_q <= rx_cnt_q + 4'h1;
			case (rx_st_q)
				RX_IDLE: begin
					if (start_seen) begin
						rx_st_q <= RX_DATA;
						rx_bits_q <= '0;
					end else if (!sync_mode && os_tick && !rx_in) begin
						rx_st_q <= RX_START;
						rx_cnt_q <= '0;
					end
				end
				RX_START: begin
					if (start_seen) begin
						rx_st_q <= RX_DATA;
						rx_bits_q <= '0;
						rx_cnt_q <= '0;
					end else if (os_tick && rx_cnt_q == OS_MID) begin
						rx_st_q <= RX_IDLE;
					end
				end
				RX_DATA: if (rx_samp) begin
					rsr_q <= {rx_in, rsr_q[8:1]}; // [R12]
					rx_bits_q <= rx_bits_q + 4'h1;
					if (rx_bits_q + 4'h1 == nbits) rx_st_q <= par_en ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_samp) begin
					rx_parbit_q <= rx_in;
					rx_st_q <= RX_STOP;
				end
				// Back to idle after the first stop; a second stop looks idle
				RX_STOP: if (rx_samp) rx_st_q <= RX_IDLE; // [R12]
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Shift-register holding slot; a frame that finds it occupied while the buffer is full is lost
	assign rx_full = (rx_count_q == RXBUF_DEPTH);
	assign push = hold_v_q & ~rx_full;
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !rx_en) begin
			hold_v_q <= 1'b0;
			hold_q <= '0;
		end else if (frame_done && (!hold_v_q || push)) begin
			hold_q.ninth <= rx_aligned[8];
			hold_q.data <= rx_aligned[7:0];
			hold_q.fe <= frame_fe;
			hold_q.overrun_flag <= 1'b0;
			hold_q.pe <= par_en & ((^rx_aligned) ^ par_odd ^ rx_parbit_q);
			hold_v_q <= 1'b1;
		end else if (push) begin
			hold_v_q <= 1'b0;
		end else if (start_seen && hold_v_q && rx_full) begin
			hold_q.overrun_flag <= 1'b1; // [R23]
		end
	end

	// Two-entry receive buffer; flushed whenever the receiver is off
	assign pop = rd_acc & (avs_address_i == OFS_DATA) & rx_complete_flag; // [R16]
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !rx_en) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			rx_count_q <= '0; // [R18]
		end else begin
			if (push) wr_ptr_q <= ~wr_ptr_q;
			if (pop) rd_ptr_q <= ~rd_ptr_q;
			rx_count_q <= rx_count_q + {1'b0, push} - {1'b0, pop}; // [R23]
		end
	end

	// Storage needs no reset: the count tells which entries are live
	always_ff @(posedge clk_i) begin
		if (push) rxbuf_q[wr_ptr_q] <= hold_q; // [R13] [R16]
	end

	assign rx_complete_flag = (rx_count_q != 2'h0); // [R17]
	assign head = rx_complete_flag ? rxbuf_q[rd_ptr_q] : '0;
	assign rx_complete_irq_o = ctrl_q[CT_RX_COMPLETE_IRQ_ENABLE] & rx_complete_flag; // [R19]

	// ----------------------------------------------------------------
	// Read data, captured in the wait cycle
	// ----------------------------------------------------------------
	always_comb begin
		st_rd = 8'h00;
		st_rd[ST_RXC] = rx_complete_flag;
		st_rd[ST_TXC] = txc_q;
		st_rd[ST_TX_BUF_EMPTY_FLAG] = ~txbuf_full_q; // [R2]
		st_rd[ST_FE] = head.fe; // [R16]
		st_rd[ST_DOR] = head.overrun_flag;
		st_rd[ST_PE] = head.pe;
		ctrl_rd = ctrl_q;
		ctrl_rd[CT_RXB9] = head.ninth; // [R16]
	end

	// Status writes touch only the complete flag; other bits are ignored
	always_ff @(posedge clk_i) begin
		if (!nrst_i) rdata_q <= '0;
		else if (avs_read_i && !ack_q) begin
			case (avs_address_i)
				OFS_DATA: rdata_q <= {24'h000000, head.data}; // [R14]
				OFS_STATUS: rdata_q <= {24'h000000, st_rd}; // [R20]
				OFS_CONTROL: rdata_q <= {24'h000000, ctrl_rd};
				OFS_FORMAT: rdata_q <= {26'h0000000, fmt_q};
				OFS_BAUD: rdata_q <= {16'h0000, baud_q};
				default: rdata_q <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	data_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R3]
		wsel_data |=> txbuf_full_q && !st_rd[ST_TX_BUF_EMPTY_FLAG]) else $error("data write did not fill buffer");
	tx_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R21]
		(tx_st_q == TX_IDLE && tx_active_q && txbuf_full_q && !wsel_data)
		|=> (tx_st_q == TX_START && !txbuf_full_q && !txd_q)) else $error("idle shifter not loaded");
	txc_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R5]
		(last_stop && !txbuf_full_q) |=> txc_q ##1 txc_q || $past(txc_clr))
		else $error("complete flag not set");
	txc_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R6]
		(txc_clr && !(last_stop && !txbuf_full_q)) |=> !txc_q) else $error("complete flag not cleared");
	txc_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R7]
		($rose(txc_q) && ctrl_q[CT_TX_COMPLETE_IRQ_ENABLE]) |-> tx_complete_irq_o) else $error("no complete request");
	tx_buf_empty_flag_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R4]
		tx_empty_irq_o == (ctrl_q[CT_TX_EMPTY_IRQ_ENABLE] && st_rd[ST_TX_BUF_EMPTY_FLAG])) else $error("no empty request");
	tx_disable_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R9]
		$fell(txd_oe_o) |-> ($past(tx_st_q) == TX_IDLE && !$past(txbuf_full_q)))
		else $error("transmitter released while busy");
	parity_slot_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R8]
		(tx_st_q == TX_PAR) |-> (txd_q == tx_par_q && par_en)) else $error("wrong parity slot");
	stop_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R22]
		(tx_st_q == TX_STOP1 || tx_st_q == TX_STOP2) |-> txd_q) else $error("stop bit not high");
	rx_flush_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R18]
		!rx_en |=> (!rx_complete_flag && !rx_complete_irq_o)) else $error("buffer not flushed");
	rx_push_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R13]
		(rx_en && frame_done && !hold_v_q && !rx_full && !pop) |=> ##1 rx_complete_flag)
		else $error("frame not buffered");
	rx_pop_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [R17]
		(pop && rx_count_q == 2'h1 && !push && rx_en) |=> !rx_complete_flag) else $error("pop left flag set");
endmodule : uart_core

// [uart_peer.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Remote serial peer: frames onto the receive pin, captures transmit
// ----------------------------------------------------------------
module uart_peer #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk_i,
	input wire logic txd_i,
	input wire logic [3:0] bits_i,
	output logic rxd_o
);
	logic [9:0] got_q[$];

	// Line idles high so the receiver never sees a false start
	initial rxd_o = 1'b1;

	// One frame: low start, bits LSB first, then the given stop level
	task automatic send(input logic [9:0] w, input int n, input logic stop);
		rxd_o <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= w[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rxd_o <= stop;
		repeat (BIT_CLKS) @(posedge clk_i);
		rxd_o <= 1'b1;
		// Two idle bits keep a bad stop from looking like the next start
		repeat (2 * BIT_CLKS) @(posedge clk_i);
	endtask : send

	// Samples each bit at its centre; the stop level lands in the top slot
	initial begin : capture
		logic [9:0] w;
		forever begin
			@(negedge txd_i);
			w = 10'h000;
			repeat (BIT_CLKS / 2) @(posedge clk_i);
			for (int i = 0; i <= bits_i; i++) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				w[i] = txd_i;
			end
			got_q.push_back(w);
		end
	end
endmodule : uart_peer

// [testbench.sv]
`timescale 1ns/10ps
module testbench import uart_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic txc_ack = 1'b0;
	logic [3:0] peer_bits = 4'h9;
	logic ext_serial_clock = 1'b0;
	logic [31:0] rdata;
	logic waitreq, txd, txd_oe, rxd_owned, empty_irq, txc_irq, rxc_irq, rxd;
	int errors = 0;
	int checks_done = 0;

	`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
		$display("ERROR %0t: got %h expected %h", $time, got, exp); end end

	// ----------------------------------------------------------------
	// Clock, design and peer
	// ----------------------------------------------------------------
	initial forever #12.5 clk = ~clk;

	// Byte lanes are tied; the external clock only toggles in the sync receive test
	uart_core u_dut (.clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .rxd_i(rxd), .xck_i(ext_serial_clock),
		.tx_complete_irq_ack_i(txc_ack), .txd_o(txd), .txd_oe_o(txd_oe),
		.rxd_owned_o(rxd_owned), .tx_empty_irq_o(empty_irq), .tx_complete_irq_o(txc_irq),
		.rx_complete_irq_o(rxc_irq));

	uart_peer #(.BIT_CLKS(16)) u_peer (.clk_i(clk), .txd_i(txd), .bits_i(peer_bits),
		.rxd_o(rxd));

	// ----------------------------------------------------------------
	// Bus access and helpers
	// ----------------------------------------------------------------
	// Request held until waitrequest is seen low; no fixed latency assumed
	task automatic bus(input logic is_rd, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		addr <= a;
		wdata <= d;
		rd_en <= is_rd;
		wr_en <= !is_rd;
		@(posedge clk);
		while (waitreq !== 1'b0) @(posedge clk);
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask : wr

	task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		`CHK(q, e)
	endtask : chk_rd

	task automatic wait_frames(input int n);
		for (int i = 0; i < 4000 && u_peer.got_q.size() < n; i++) @(posedge clk);
	endtask : wait_frames

	task automatic wait_txc;
		for (int i = 0; i < 400 && txc_irq !== 1'b1; i++) @(posedge clk);
		@(posedge clk);
	endtask : wait_txc

	// One synchronous bit: data changes with the low phase, sampled on the rise
	task automatic sync_bit(input logic b);
		u_peer.rxd_o <= b;
		ext_serial_clock <= 1'b0;
		repeat (4) @(posedge clk);
		ext_serial_clock <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : sync_bit

	task end_of_test;
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	// Whole run needs some 2200 cycles; this is far beyond it
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset state and an unmapped address
		chk_rd(OFS_STATUS, 32'h04);
		chk_rd(OFS_CONTROL, 32'h00);
		chk_rd(OFS_FORMAT, 32'h03);
		chk_rd(5'h14, 32'h00);
		`CHK(txd, 1'b1)
		`CHK(txd_oe, 1'b0)
		// Nine-bit transmit, two back to back, ninth bit changed after the second write
		wr(OFS_FORMAT, 32'h07);
		wr(OFS_CONTROL, 32'h3a);
		`CHK(empty_irq, 1'b1)
		wr(OFS_DATA, 32'ha5);
		wr(OFS_DATA, 32'h3c);
		chk_rd(OFS_STATUS, 32'h00);
		`CHK(empty_irq, 1'b0)
		wr(OFS_CONTROL, 32'h1a);
		wait_frames(2);
		`CHK(u_peer.got_q[0], 10'h3a5)
		`CHK(u_peer.got_q[1], 10'h33c)
		wait_txc();
		chk_rd(OFS_STATUS, 32'h06);
		`CHK(txc_irq, 1'b1)
		wr(OFS_STATUS, 32'h00);
		chk_rd(OFS_STATUS, 32'h06);
		wr(OFS_STATUS, 32'h02);
		chk_rd(OFS_STATUS, 32'h04);
		// Even parity, then disable while the frame is still pending
		u_peer.got_q.delete();
		wr(OFS_FORMAT, 32'h13);
		wr(OFS_CONTROL, 32'h0a);
		wr(OFS_DATA, 32'h07);
		wr(OFS_CONTROL, 32'h08);
		`CHK(txd_oe, 1'b1)
		wait_frames(1);
		`CHK(u_peer.got_q[0], 10'h307)
		wait_txc();
		`CHK(txd_oe, 1'b0)
		txc_ack <= 1'b1;
		@(posedge clk);
		txc_ack <= 1'b0;
		@(posedge clk);
		chk_rd(OFS_STATUS, 32'h04);
		// Nine-bit receive: fill both slots and the shifter, then lose a fourth frame
		wr(OFS_FORMAT, 32'h07);
		wr(OFS_CONTROL, 32'h05);
		`CHK(rxd_owned, 1'b1)
		`CHK(rxc_irq, 1'b0)
		u_peer.send(10'h155, 9, 1'b1);
		u_peer.send(10'h0aa, 9, 1'b1);
		u_peer.send(10'h0f0, 9, 1'b1);
		u_peer.send(10'h033, 9, 1'b1);
		`CHK(rxc_irq, 1'b1)
		chk_rd(OFS_STATUS, 32'h05);
		chk_rd(OFS_CONTROL, 32'h45);
		chk_rd(OFS_DATA, 32'h55);
		chk_rd(OFS_CONTROL, 32'h05);
		chk_rd(OFS_DATA, 32'haa);
		chk_rd(OFS_STATUS, 32'h15);
		chk_rd(OFS_DATA, 32'hf0);
		chk_rd(OFS_STATUS, 32'h04);
		`CHK(rxc_irq, 1'b0)
		// Seven-bit receive: upper bit masked, broken stop flagged on its own entry
		wr(OFS_FORMAT, 32'h02);
		u_peer.send(10'h07f, 7, 1'b1);
		u_peer.send(10'h015, 7, 1'b0);
		chk_rd(OFS_DATA, 32'h7f);
		chk_rd(OFS_STATUS, 32'h0d);
		chk_rd(OFS_DATA, 32'h15);
		// Unread data is lost when the receiver is switched off
		u_peer.send(10'h02a, 7, 1'b1);
		`CHK(rxc_irq, 1'b1)
		wr(OFS_CONTROL, 32'h04);
		chk_rd(OFS_STATUS, 32'h04);
		`CHK(rxd_owned, 1'b0)
		`CHK(rxc_irq, 1'b0)
		// Synchronous seven-bit receive clocked by the external pin
		wr(OFS_CONTROL, 32'h85);
		sync_bit(1'b0);
		for (int i = 0; i < 7; i++) sync_bit(i[0] ? 1'b1 : 1'b0);
		sync_bit(1'b1);
		repeat (8) @(posedge clk);
		chk_rd(OFS_STATUS, 32'h05);
		chk_rd(OFS_DATA, 32'h2a);
		chk_rd(OFS_STATUS, 32'h04);
		end_of_test();
	end
endmodule : testbench
